// ===== hw/vofs_defines.svh
// constants for the valve output fault supervisor
`ifndef VOFS_DEFINES_SVH
`define VOFS_DEFINES_SVH
`define VOFS_OFF_CTRL      12'h000
`define VOFS_OFF_STATUS    12'h004
`define VOFS_OFF_MASK      12'h008
`define VOFS_OFF_PARAM     12'h00C
`define VOFS_OFF_HT_KEY    12'h010
`define VOFS_OFF_FAULTACT  12'h014
`define VOFS_OFF_THRESH    12'h018
`define VOFS_OFF_COUNT     12'h01C
`define VOFS_OFF_CHSEL     12'h020
`define VOFS_PB_PRIO       0
`define VOFS_PB_CMON       1
`define VOFS_PB_OMON       2
`define VOFS_PB_SCDET      3
`define VOFS_PB_RSTMODE    4
`define VOFS_PB_OCDET      5
`define VOFS_PB_CNTERR     6
`define VOFS_PARAM_RESET   32'h0000000E
`define VOFS_HT_KEY_VALUE  32'h0000A5C3
`define VOFS_CNT_SCALE     1000
`define VOFS_SAVE_PERIOD_S 30
`define VOFS_CLK_HZ        50000000
`define VOFS_SAVE_CYCLES   (`VOFS_SAVE_PERIOD_S * `VOFS_CLK_HZ)
`define VOFS_ST_CSUP       0
`define VOFS_ST_OSUP       1
`define VOFS_ST_SHORT      2
`define VOFS_ST_OPEN       3
`define VOFS_ST_CNT        4
`endif

// ===== hw/vofs_pkg.sv
// types for the valve output fault supervisor
package vofs_pkg;
    typedef enum logic [1:0] {
        VOFS_ACT_CLEAR = 2'h0,
        VOFS_ACT_HOLD  = 2'h1,
        VOFS_ACT_FORCE = 2'h2
    } vofs_action_e;
    typedef struct packed {
        logic cntr_err_en;
        logic open_det_en;
        logic short_manual;
        logic short_det_en;
        logic out_mon_en;
        logic ctrl_mon_en;
        logic prio_handheld;
    } vofs_param_s;
    typedef enum logic [2:0] {
        VOFS_SV_IDLE  = 3'b001,
        VOFS_SV_WRITE = 3'b010,
        VOFS_SV_NEXT  = 3'b100
    } vofs_save_e;
endpackage

// ===== hw/vofs_top.sv
// valve output fault supervisor with apb register slave
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "vofs_defines.svh"
// Operation
// - fault output source chosen by priority bit: unit switch default, else handheld
// - per-channel fault action used only when handheld priority selected
// - on comm fault each output clears, holds or forces on; clear default
// - control supply monitor (default on) flags over 26V or under 20V
// - output supply monitor (default on) flags over 26V or under 21V
// - short detection (default on) flags a valve short circuit
// - auto restart clears short error once the short is gone
// - manual restart keeps short error until power is reapplied
// - open detection (default off) flags a disconnected valve per channel
// - each channel counts its own valve on operations
// - counter error (default off) flags when count exceeds threshold
// - threshold setting is scaled by one thousand operations
// - each count is saved to nonvolatile storage every thirty seconds
// - after power up counts resume from the saved values
// - parameters writable only by handheld terminal, never over fieldbus
module vofs_top #(
    parameter int          NCH         = 8,
    parameter int          CW          = 32,
    parameter logic [31:0] SAVE_CYCLES = 32'(`VOFS_SAVE_CYCLES)
) (
    input  wire logic            sys_clk,      // 50 MHz clock
    input  wire logic            rst,          // sync reset, high
    input  wire logic            psel,         // apb select
    input  wire logic            penable,      // apb access phase
    input  wire logic            pwrite,       // apb direction
    input  wire logic [11:0]     paddr,        // apb byte address
    input  wire logic [31:0]     pwdata,       // apb write data
    input  wire logic            ht_source,    // access from handheld
    output logic                 pready,       // apb ready
    output logic [31:0]          prdata,       // apb read data
    output logic                 pslverr,      // apb error
    input  wire logic            comm_ok,      // fieldbus link healthy
    input  wire logic [NCH-1:0]  bus_out,      // outputs from master
    input  wire logic [2*NCH-1:0] sw_action,   // unit switch actions
    input  wire logic            ctrl_v_high,  // control supply >26V
    input  wire logic            ctrl_v_low,   // control supply <20V
    input  wire logic            out_v_high,   // output supply >26V
    input  wire logic            out_v_low,    // output supply <21V
    input  wire logic            short_det,    // valve short seen
    input  wire logic [NCH-1:0]  open_det,     // valve open seen
    input  wire logic            nv_load,      // restore pulse
    input  wire logic [CW-1:0]   nv_rdata,     // restore count
    input  wire logic [$clog2(NCH)-1:0] nv_rch, // restore channel
    output logic                 nv_we,        // save strobe
    output logic [$clog2(NCH)-1:0] nv_wch,     // save channel
    output logic [CW-1:0]        nv_wdata,     // save count
    output logic [NCH-1:0]       valve_out,    // valve drives
    output logic                 ctrl_sup_err, // control supply error
    output logic                 out_sup_err,  // output supply error
    output logic                 short_err,    // short error
    output logic [NCH-1:0]       open_err,     // open errors
    output logic [NCH-1:0]       cnt_err,      // counter errors
    output logic                 irq           // interrupt level
);
    localparam int CHW = $clog2(NCH);

    logic [NCH-1:0]          out_reg, out_next;
    vofs_pkg::vofs_param_s   param_reg;
    logic [2*NCH-1:0]        faultact_reg;
    logic [15:0]             thresh_reg;
    logic [CHW-1:0]          chsel_reg;
    logic [4:0]              status_reg, mask_reg;
    logic [CW-1:0]           cnt_reg [NCH];
    logic [NCH-1:0]          prev_out_reg;
    logic                    short_latch_reg;
    logic [31:0]             save_tmr_reg;
    logic [CHW-1:0]          save_ch_reg;
    vofs_pkg::vofs_save_e    sv_state_reg;

    function automatic logic [1:0] act_of(input logic [2*NCH-1:0] v,
                                          input int ch);
        act_of = v[2*ch +: 2];
    endfunction

    // apb decode; one-cycle access, pready always high
    wire acc      = psel & penable;
    wire wr       = acc & pwrite;
    wire hit_ctrl = paddr == `VOFS_OFF_CTRL;
    wire hit_st   = paddr == `VOFS_OFF_STATUS;
    wire hit_mask = paddr == `VOFS_OFF_MASK;
    wire hit_par  = paddr == `VOFS_OFF_PARAM;
    wire hit_key  = paddr == `VOFS_OFF_HT_KEY;
    wire hit_fa   = paddr == `VOFS_OFF_FAULTACT;
    wire hit_th   = paddr == `VOFS_OFF_THRESH;
    wire hit_cnt  = paddr == `VOFS_OFF_COUNT;
    wire hit_cs   = paddr == `VOFS_OFF_CHSEL;
    wire mapped   = hit_ctrl | hit_st | hit_mask | hit_par | hit_key |
                    hit_fa | hit_th | hit_cnt | hit_cs;
    // parameter writes need handheld origin; fieldbus writes are refused
    wire par_hit  = hit_par | hit_fa | hit_th;
    wire par_wr   = wr & ht_source;
    wire refused  = wr & par_hit & ~ht_source;
    assign pready  = 1'b1;
    assign pslverr = acc & (~mapped | refused);

    // supervised event levels
    wire ev_csup  = param_reg.ctrl_mon_en & (ctrl_v_high | ctrl_v_low);
    wire ev_osup  = param_reg.out_mon_en & (out_v_high | out_v_low);
    wire ev_short = param_reg.short_det_en & short_det;
    wire [NCH-1:0] ev_open = {NCH{param_reg.open_det_en}} & open_det;
    wire [CW+15:0] lim = CW'(thresh_reg) * (CW+16)'(`VOFS_CNT_SCALE);
    logic [NCH-1:0] over;
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            over[i] = (CW+16)'(cnt_reg[i]) > lim;
        end
    end
    wire [NCH-1:0] ev_cnt = {NCH{param_reg.cntr_err_en}} & over;
    // short error: auto follows the detector, manual sticks until reset
    assign short_err = ev_short | (param_reg.short_manual & short_latch_reg);
    assign ctrl_sup_err = ev_csup;
    assign out_sup_err  = ev_osup;
    assign open_err     = ev_open;
    assign cnt_err      = ev_cnt;
    wire [4:0] ev_vec = {|ev_cnt, |ev_open, short_err, ev_osup, ev_csup};
    assign irq = |(status_reg & mask_reg);

    // output selection on comm fault
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            logic [1:0] a;
            a = param_reg.prio_handheld ? act_of(faultact_reg, i)
                                        : act_of(sw_action, i);
            if (comm_ok) begin
                out_next[i] = bus_out[i];
            end else if (a == 2'(vofs_pkg::VOFS_ACT_FORCE)) begin
                out_next[i] = 1'b1;
            end else if (a == 2'(vofs_pkg::VOFS_ACT_HOLD)) begin
                out_next[i] = out_reg[i];
            end else begin
                out_next[i] = 1'b0;
            end
        end
    end
    assign valve_out = out_reg;

    // register file; set beats write-one-clear in status
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            param_reg    <= vofs_pkg::vofs_param_s'(7'(`VOFS_PARAM_RESET));
            faultact_reg <= '0;
            thresh_reg   <= 16'h0001;
            mask_reg     <= 5'h00;
            chsel_reg    <= '0;
            status_reg   <= 5'h00;
        end else begin
            if (par_wr && hit_par)
                param_reg <= vofs_pkg::vofs_param_s'(pwdata[6:0]);
            if (par_wr && hit_fa)
                faultact_reg <= pwdata[2*NCH-1:0];
            if (par_wr && hit_th && pwdata[15:0] != 16'h0000 &&
                pwdata[15:0] <= 16'hFDE8)
                thresh_reg <= pwdata[15:0];
            if (wr && hit_mask)
                mask_reg <= pwdata[4:0];
            if (wr && hit_cs)
                chsel_reg <= pwdata[CHW-1:0];
            status_reg <= (status_reg & ~((wr && hit_st) ? pwdata[4:0]
                                                          : 5'h00)) | ev_vec;
        end
    end

    // read mux, registered into prdata
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            unique case (1'b1)
                hit_ctrl: prdata <= 32'({comm_ok, short_err, ev_osup, ev_csup});
                hit_st:   prdata <= 32'(status_reg);
                hit_mask: prdata <= 32'(mask_reg);
                hit_par:  prdata <= 32'(param_reg);
                hit_fa:   prdata <= 32'(faultact_reg);
                hit_th:   prdata <= 32'(thresh_reg);
                hit_cnt:  prdata <= 32'(cnt_reg[chsel_reg]);
                hit_cs:   prdata <= 32'(chsel_reg);
                default:  prdata <= 32'h00000000;
            endcase
        end
    end

    // outputs, short latch and per-channel on counters
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_reg         <= '0;
            prev_out_reg    <= '0;
            short_latch_reg <= 1'b0;
        end else begin
            out_reg         <= out_next;
            prev_out_reg    <= out_reg;
            // in auto mode the latch follows the detector, so a stale
            // short from auto mode cannot surface when manual is chosen
            if (ev_short)
                short_latch_reg <= 1'b1;
            else if (!param_reg.short_manual)
                short_latch_reg <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < NCH; i++) begin
            if (rst)
                cnt_reg[i] <= '0;
            else if (nv_load && nv_rch == CHW'(i))
                cnt_reg[i] <= nv_rdata;
            else if (out_reg[i] && !prev_out_reg[i])
                cnt_reg[i] <= cnt_reg[i] + 1'b1;
        end
    end

    // save sequencer: one channel every two cycles every save period
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sv_state_reg <= vofs_pkg::VOFS_SV_IDLE;
            save_tmr_reg <= 32'h00000000;
            save_ch_reg  <= '0;
            nv_we        <= 1'b0;
            nv_wch       <= '0;
            nv_wdata     <= '0;
        end else begin
            nv_we <= 1'b0;
            unique case (sv_state_reg)
                vofs_pkg::VOFS_SV_IDLE: begin
                    if (save_tmr_reg == SAVE_CYCLES - 32'h1) begin
                        save_tmr_reg <= 32'h00000000;
                        save_ch_reg  <= '0;
                        sv_state_reg <= vofs_pkg::VOFS_SV_WRITE;
                    end else begin
                        save_tmr_reg <= save_tmr_reg + 32'h1;
                    end
                end
                vofs_pkg::VOFS_SV_WRITE: begin
                    // timer runs through the writes so the period is exact
                    save_tmr_reg <= save_tmr_reg + 32'h1;
                    nv_we        <= 1'b1;
                    nv_wch       <= save_ch_reg;
                    nv_wdata     <= cnt_reg[save_ch_reg];
                    sv_state_reg <= vofs_pkg::VOFS_SV_NEXT;
                end
                vofs_pkg::VOFS_SV_NEXT: begin
                    save_tmr_reg <= save_tmr_reg + 32'h1;
                    if (save_ch_reg == CHW'(NCH - 1)) begin
                        sv_state_reg <= vofs_pkg::VOFS_SV_IDLE;
                    end else begin
                        save_ch_reg  <= save_ch_reg + 1'b1;
                        sv_state_reg <= vofs_pkg::VOFS_SV_WRITE;
                    end
                end
            endcase
        end
    end

    // checks
    property p_refuse;
        @(posedge sys_clk) disable iff (rst)
        (wr && hit_par && !ht_source) |=> $stable(param_reg);
    endproperty
    a_refuse: assert property (p_refuse) else $error("fieldbus write");
    property p_clear;
        @(posedge sys_clk) disable iff (rst)
        (!comm_ok && !param_reg.prio_handheld && act_of(sw_action,0) == 2'h0)
            |=> !valve_out[0];
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");
    property p_force;
        @(posedge sys_clk) disable iff (rst)
        (!comm_ok && param_reg.prio_handheld && act_of(faultact_reg,0) == 2'h2)
            |=> valve_out[0];
    endproperty
    a_force: assert property (p_force) else $error("force failed");
    property p_hold;
        @(posedge sys_clk) disable iff (rst)
        (!comm_ok && param_reg.prio_handheld && act_of(faultact_reg,0) == 2'h1)
            |=> valve_out[0] == $past(valve_out[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("hold failed");
    property p_csup;
        @(posedge sys_clk) disable iff (rst)
        ctrl_sup_err |-> (param_reg.ctrl_mon_en && (ctrl_v_high||ctrl_v_low));
    endproperty
    a_csup: assert property (p_csup) else $error("ctrl err");
    property p_osup;
        @(posedge sys_clk) disable iff (rst)
        out_sup_err |-> (param_reg.out_mon_en && (out_v_high || out_v_low));
    endproperty
    a_osup: assert property (p_osup) else $error("out err");
    property p_manual;
        @(posedge sys_clk) disable iff (rst)
        (param_reg.short_manual && short_err && !(par_wr && hit_par))
            |=> short_err;
    endproperty
    a_manual: assert property (p_manual) else $error("manual lost");
    property p_auto;
        @(posedge sys_clk) disable iff (rst)
        (!param_reg.short_manual && !short_det) |-> !short_err;
    endproperty
    a_auto: assert property (p_auto) else $error("auto stuck");
    property p_count;
        @(posedge sys_clk) disable iff (rst)
        (out_reg[0] && !prev_out_reg[0] && !nv_load)
            |=> cnt_reg[0] == $past(cnt_reg[0]) + 1'b1;
    endproperty
    a_count: assert property (p_count) else $error("count miss");
    // parameter gates: a disabled check must stay silent (short only with auto restart), an enabled open check follows its detector
    property p_short_off;
        @(posedge sys_clk) disable iff (rst)
        (!param_reg.short_det_en && !param_reg.short_manual) |-> !short_err;
    endproperty
    a_short_off: assert property (p_short_off) else $error("short off");
    property p_open_off;
        @(posedge sys_clk) disable iff (rst)
        !param_reg.open_det_en |-> open_err == '0;
    endproperty
    a_open_off: assert property (p_open_off) else $error("open off");
    property p_open_on;
        @(posedge sys_clk) disable iff (rst)
        param_reg.open_det_en |-> open_err == open_det;
    endproperty
    a_open_on: assert property (p_open_on) else $error("open on");
    property p_cnt_off;
        @(posedge sys_clk) disable iff (rst)
        !param_reg.cntr_err_en |-> cnt_err == '0;
    endproperty
    a_cnt_off: assert property (p_cnt_off) else $error("cnt off");
    // fieldbus writes to the other parameter words leave them untouched
    property p_refuse_ch;
        @(posedge sys_clk) disable iff (rst)
        (wr && (hit_fa || hit_th) && !ht_source)
            |=> ($stable(faultact_reg) && $stable(thresh_reg));
    endproperty
    a_refuse_ch: assert property (p_refuse_ch) else $error("bus set");
    property p_sticky;
        @(posedge sys_clk) disable iff (rst)
        (status_reg[2] && !(wr && hit_st && pwdata[2]))
            |=> status_reg[2];
    endproperty
    a_sticky: assert property (p_sticky) else $error("status lost");
    property p_save;
        @(posedge sys_clk) disable iff (rst)
        (sv_state_reg == vofs_pkg::VOFS_SV_WRITE) |=> nv_we;
    endproperty
    a_save: assert property (p_save) else $error("save miss");
    c_fault: cover property (@(posedge sys_clk) !comm_ok ##1 comm_ok);
    c_short: cover property (@(posedge sys_clk) short_err ##1 !short_det);
    c_save:  cover property (@(posedge sys_clk) nv_we);
    c_manual: cover property (@(posedge sys_clk)
        param_reg.short_manual && short_err && !short_det);
    c_refuse: cover property (@(posedge sys_clk) pslverr);
endmodule

// ===== testbench/vofs_nv_model.sv
// nonvolatile count store standing beside the supervisor
`timescale 1ns/1ps
module vofs_nv_model #(
    parameter int NCH = 8,
    parameter int CW  = 32
) (
    input  wire logic                   sys_clk,  // system clock
    input  wire logic                   nv_we,    // save strobe
    input  wire logic [$clog2(NCH)-1:0] nv_wch,   // save channel
    input  wire logic [CW-1:0]          nv_wdata, // save count
    output logic                        nv_load,  // restore pulse
    output logic [CW-1:0]               nv_rdata, // restore count
    output logic [$clog2(NCH)-1:0]      nv_rch    // restore channel
);
    logic [CW-1:0] mem [NCH];
    // lines idle with junk so a load outside the pulse shows up
    initial begin
        nv_load = 1'b0;
        nv_rdata = '1;
        nv_rch = '0;
    end
    // contents survive device resets, as real storage would
    always @(posedge sys_clk) begin
        if (nv_we) begin
            mem[nv_wch] <= nv_wdata;
        end
    end
    // replay one saved count after power-up
    task automatic restore(input int ch);
        @(posedge sys_clk);
        nv_load <= 1'b1;
        nv_rch <= ($clog2(NCH))'(ch);
        nv_rdata <= mem[ch];
        @(posedge sys_clk);
        nv_load <= 1'b0;
        nv_rdata <= ~mem[ch];
    endtask
endmodule

// ===== testbench/valve_output_fault_supervisor_test.sv
// self-checking bench for the valve output fault supervisor
`timescale 1ns/1ps
`include "vofs_defines.svh"
module valve_output_fault_supervisor_test;
    logic        sys_clk, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, ht_source = 1'b0, comm_ok = 1'b1;
    logic        ctrl_v_high = 1'b0, ctrl_v_low = 1'b0, short_det = 1'b0;
    logic        out_v_high = 1'b0, out_v_low = 1'b0, err_seen;
    logic        pready, pslverr, nv_load, nv_we, irq;
    logic        ctrl_sup_err, out_sup_err, short_err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, nv_rdata, nv_wdata;
    logic [7:0]  bus_out = 8'h00, open_det = 8'h00;
    logic [7:0]  valve_out, open_err, cnt_err;
    logic [15:0] sw_action = 16'h0000;
    logic [2:0]  nv_rch, nv_wch;
    int          n_errors = 0, checks_done = 0, cyc = 0;
    // save period cut to 100 cycles to keep the run short
    vofs_top #(.SAVE_CYCLES(32'h00000064)) u_dut (
        .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .ht_source, .pready, .prdata, .pslverr, .comm_ok, .bus_out,
        .sw_action, .ctrl_v_high, .ctrl_v_low, .out_v_high, .out_v_low,
        .short_det, .open_det, .nv_load, .nv_rdata, .nv_rch, .nv_we,
        .nv_wch, .nv_wdata, .valve_out, .ctrl_sup_err, .out_sup_err,
        .short_err, .open_err, .cnt_err, .irq
    );
    vofs_nv_model u_nv (
        .sys_clk, .nv_we, .nv_wch, .nv_wdata, .nv_load, .nv_rdata, .nv_rch
    );
    // 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // a hang ends the run as a failure
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic ticks(int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one apb transfer; answer taken only at the edge with pready high
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic ht);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        ht_source <= ht;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        // only the bench timeout ends this wait
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d, logic ht);
        apb(1'b1, a, d, ht);
    endtask
    task automatic rdchk(string n, logic [11:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0, 1'b0);
        check(n, rd, e);
    endtask
    // n rising edges on channel 0, then let the count settle
    task automatic toggle(int n);
        repeat (n) begin
            bus_out <= 8'h01;
            ticks(1);
            bus_out <= 8'h00;
            ticks(1);
        end
        ticks(3);
    endtask
    // link drops while master data changes, then comes back
    task automatic fault(logic [7:0] e);
        comm_ok <= 1'b0;
        bus_out <= 8'hAA;
        ticks(2);
        check("valve out in fault", valve_out, e);
        comm_ok <= 1'b1;
        ticks(2);
        check("valve out linked", valve_out, 8'hAA);
        bus_out <= 8'h55;
        ticks(2);
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rdchk("ctrl", `VOFS_OFF_CTRL, 32'h00000008);
        rdchk("param", `VOFS_OFF_PARAM, 32'h0000000E);
        rdchk("thresh", `VOFS_OFF_THRESH, 32'h00000001);
        wr(`VOFS_OFF_PARAM, 32'h0000000F, 1'b0);
        check("param refused", err_seen, 1'b1);
        rdchk("param kept", `VOFS_OFF_PARAM, 32'h0000000E);
        wr(`VOFS_OFF_THRESH, 32'h0000FDE9, 1'b1);
        rdchk("thresh range", `VOFS_OFF_THRESH, 32'h00000001);
        apb(1'b0, 12'h040, 32'h0, 1'b0);
        check("unmapped", err_seen, 1'b1);
        // every supply limit with monitors on, then off
        for (int m = 0; m < 2; m++) begin
            if (m == 1) wr(`VOFS_OFF_PARAM, 32'h00000008, 1'b1);
            for (int i = 0; i < 4; i++) begin
                ctrl_v_high <= (i == 0);
                ctrl_v_low  <= (i == 1);
                out_v_high  <= (i == 2);
                out_v_low   <= (i == 3);
                ticks(2);
                check("ctrl sup err", ctrl_sup_err, m == 0 && i < 2);
                check("out sup err", out_sup_err, m == 0 && i > 1);
            end
        end
        ctrl_v_high <= 1'b0;
        ctrl_v_low  <= 1'b0;
        out_v_high  <= 1'b0;
        out_v_low   <= 1'b0;
        wr(`VOFS_OFF_STATUS, 32'h0000001F, 1'b0);
        // count right up to setting one times one thousand
        wr(`VOFS_OFF_PARAM, 32'h00000048, 1'b1);
        wr(`VOFS_OFF_CHSEL, 32'h0, 1'b0);
        toggle(1000);
        check("cnt err at limit", cnt_err, 8'h00);
        rdchk("count", `VOFS_OFF_COUNT, 32'h000003E8);
        toggle(1);
        check("cnt err over", cnt_err, 8'h01);
        wr(`VOFS_OFF_CHSEL, 32'h1, 1'b0);
        rdchk("count ch1", `VOFS_OFF_COUNT, 32'h0);
        ticks(250);
        check("saved ch0", u_nv.mem[0], 32'h000003E9);
        // short event raises irq; counter bit stays masked
        short_det <= 1'b1;
        ticks(2);
        check("short", short_err, 1'b1);
        wr(`VOFS_OFF_MASK, 32'h00000004, 1'b0);
        ticks(1);
        check("irq", irq, 1'b1);
        short_det <= 1'b0;
        ticks(2);
        check("short auto", short_err, 1'b0);
        rdchk("status", `VOFS_OFF_STATUS, 32'h00000014);
        wr(`VOFS_OFF_STATUS, 32'h00000004, 1'b0);
        ticks(1);
        check("irq cleared", irq, 1'b0);
        // manual recovery keeps the error until power-up
        wr(`VOFS_OFF_PARAM, 32'h00000058, 1'b1);
        check("short manual idle", short_err, 1'b0);
        short_det <= 1'b1;
        ticks(2);
        short_det <= 1'b0;
        ticks(2);
        check("short held", short_err, 1'b1);
        rst <= 1'b1;
        ticks(2);
        rst <= 1'b0;
        ticks(1);
        check("short after power-up", short_err, 1'b0);
        u_nv.restore(0);
        u_nv.restore(1);
        rdchk("count restored", `VOFS_OFF_COUNT, 32'h000003E9);
        toggle(1);
        rdchk("count resumed", `VOFS_OFF_COUNT, 32'h000003EA);
        // switch actions per channel clear,hold,force; table reversed
        sw_action <= 16'h4924;
        bus_out <= 8'h55;
        wr(`VOFS_OFF_FAULTACT, 32'h00006186, 1'b1);
        wr(`VOFS_OFF_FAULTACT, 32'h0000FFFF, 1'b0);
        check("faultact refused", err_seen, 1'b1);
        rdchk("faultact", `VOFS_OFF_FAULTACT, 32'h00006186);
        fault(8'h34);
        wr(`VOFS_OFF_PARAM, 32'h0000000F, 1'b1);
        fault(8'h59);
        // open detection off by default, then on with short detect off
        short_det <= 1'b1;
        open_det <= 8'h5A;
        ticks(2);
        check("open default", open_err, 8'h00);
        wr(`VOFS_OFF_PARAM, 32'h00000020, 1'b1);
        ticks(1);
        check("short off", short_err, 1'b0);
        check("open", open_err, 8'h5A);
        close_out();
    end
endmodule
